// File: ccdr_params.svh
// Timing and geometry constants for the CCD readout sequencer
`ifndef CCDR_PARAMS_SVH
`define CCDR_PARAMS_SVH
`define CCDR_CLK_NS         50
`define CCDR_PIX_NS         250
`define CCDR_PIX_CYC        (`CCDR_PIX_NS / `CCDR_CLK_NS)
`define CCDR_ACT_COLS       2614
`define CCDR_ACT_ROWS       1966
`define CCDR_DARK_COLS      34
`define CCDR_DARK_LEAD_ROWS 34
`define CCDR_DARK_TAIL_ROWS 4
`define CCDR_BUF_PIX        20
`define CCDR_DUMMY_LEAD     12
`define CCDR_DUMMY_TAIL     2
`define CCDR_EDGE_ROWS      2
`define CCDR_VPHASE_CYC     200
`define CCDR_VCNT_W         16
`define CCDR_PCNT_W         12
`define CCDR_LCNT_W         12
`endif

// File: ccdr_pkg.sv
// Types for the CCD readout sequencer
package ccdr_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_INTEG,
    ST_V1,
    ST_V2,
    ST_HOLD,
    ST_HSHIFT
  } ccdr_state_e;
  typedef enum logic [2:0] {
    PX_DUMMY_LEAD,
    PX_DARK,
    PX_BUFFER,
    PX_ACTIVE,
    PX_DUMMY_TAIL
  } ccdr_pix_e;
endpackage : ccdr_pkg

// File: ccdr_pix_class.sv
// Classifies a horizontal position and a line into pixel kinds and flags
`include "ccdr_params.svh"
module ccdr_pix_class
  import ccdr_pkg::*;
#(
  parameter int PW = `CCDR_PCNT_W,
  parameter int LW = `CCDR_LCNT_W
) (
  // Position
  input  wire logic [PW-1:0]   i_pix,
  input  wire logic [LW-1:0]   i_line,
  // Result
  output ccdr_pkg::ccdr_pix_e  o_kind,
  output logic                 o_dark_clean,
  output logic                 o_buffer,
  output logic                 o_suspect
);
  import ccdr_pkg::*;

  localparam int C_DL = `CCDR_DUMMY_LEAD;
  localparam int C_D1 = C_DL + `CCDR_DARK_COLS;
  localparam int C_A  = C_D1 + `CCDR_ACT_COLS;
  localparam int C_D2 = C_A + `CCDR_DARK_COLS;
  localparam int C_TL = C_D2 + `CCDR_DUMMY_TAIL;
  localparam int L_D1 = `CCDR_DARK_LEAD_ROWS;
  localparam int L_A  = L_D1 + `CCDR_ACT_ROWS;
  localparam int L_TL = L_A + `CCDR_DARK_TAIL_ROWS;
  localparam int B    = `CCDR_BUF_PIX;

  int p;
  int l;
  logic col_dark;
  logic row_dark;
  always_comb begin
    p = int'(i_pix);
    l = int'(i_line);
    col_dark = (p >= C_DL && p < C_D1) || (p >= C_A && p < C_D2);
    row_dark = (l < L_D1) || (l >= L_A);
    if (p < C_DL) begin
      o_kind = PX_DUMMY_LEAD;
    end else if (p >= C_D2) begin
      o_kind = PX_DUMMY_TAIL;
    end else if (col_dark || row_dark) begin
      o_kind = PX_DARK;
    end else if (p < C_D1 + B || p >= C_A - B || l < L_D1 + B || l >= L_A - B) begin
      o_kind = PX_BUFFER;
    end else begin
      o_kind = PX_ACTIVE;
    end
    o_buffer = (o_kind == PX_BUFFER);
    // Dark next to active area, chip edge or first lines out may scavenge
    o_suspect = (o_kind == PX_DUMMY_LEAD) ||
                (o_kind == PX_DARK && (l < `CCDR_EDGE_ROWS || l == L_D1 - 1 ||
                 l == L_A || l == L_TL - 1 || p == C_DL || p == C_D1 - 1 ||
                 p == C_A || p == C_D2 - 1));
    o_dark_clean = (o_kind == PX_DARK) && !o_suspect;
  end
endmodule : ccdr_pix_class

// File: ccdr_seq.sv
// Readout sequencer that clocks a full-frame CCD and tags each sample
// What this block does
// - Both vertical clocks stay low during the whole exposure.
// - Row transfer on falling vert_clk_a while horiz_clk_b is held high.
// - Horizontal clocks toggle alternately and complementarily, one pixel per five clock cycles.
// - Reset gate pulses only after the sample strobe for the pixel.
// - Reset gate pulses once in every pixel period throughout readout.
// - One pixel period lasts 250 ns.
`include "ccdr_params.svh"
module ccdr_seq
  import ccdr_pkg::*;
#(
  parameter int INTEG_CYC = 4096,
  parameter int VPH_CYC   = `CCDR_VPHASE_CYC,
  parameter int HS_CYC    = `CCDR_VPHASE_CYC
) (
  // Clock and reset
  input  wire logic                    I_CLK,
  input  wire logic                    I_RESET_N,
  // Control
  input  wire logic                    I_START,
  input  wire logic [`CCDR_VCNT_W-1:0] I_INTEG_LEN,
  // CCD clock pins
  output logic                         O_VERT_CLK_A,
  output logic                         O_VERT_CLK_B,
  output logic                         O_HORIZ_CLK_A,
  output logic                         O_HORIZ_CLK_B,
  output logic                         O_FD_RESET_GATE,
  // Sample side
  output logic                         O_SAMPLE,
  output ccdr_pkg::ccdr_pix_e          O_PIX_KIND,
  output logic                         O_DARK_CLEAN,
  output logic                         O_BUFFER,
  output logic                         O_SUSPECT,
  output logic [`CCDR_PCNT_W-1:0]      O_PIX,
  output logic [`CCDR_LCNT_W-1:0]      O_LINE,
  output logic                         O_BUSY,
  output logic                         O_FRAME_DONE
);
  import ccdr_pkg::*;

  localparam int PIX_CYC = `CCDR_PIX_CYC;
  localparam logic [`CCDR_PCNT_W-1:0] LINE_PIX = `CCDR_PCNT_W'(`CCDR_DUMMY_LEAD +
      2 * `CCDR_DARK_COLS + `CCDR_ACT_COLS + `CCDR_DUMMY_TAIL);
  localparam logic [`CCDR_LCNT_W-1:0] FRAME_LINES = `CCDR_LCNT_W'(`CCDR_DARK_LEAD_ROWS +
      `CCDR_ACT_ROWS + `CCDR_DARK_TAIL_ROWS);

  // ***************
  // State
  // ***************
  typedef struct packed {
    ccdr_state_e               st;
    logic [`CCDR_VCNT_W-1:0]   cnt;
    logic [2:0]                ph;
    logic [`CCDR_PCNT_W-1:0]   pix;
    logic [`CCDR_LCNT_W-1:0]   line;
    logic                      va;
    logic                      vb;
    logic                      ha;
    logic                      hb;
    logic                      rg;
    logic                      smp;
    logic                      done;
    ccdr_pix_e                 kind;
    logic                      clean;
    logic                      buf_f;
    logic                      sus;
    logic                      busy;
  } ccdr_state_s;

  ccdr_state_s s_q;
  ccdr_state_s s_d;
  ccdr_pix_e   c_kind;
  logic        c_clean;
  logic        c_buf;
  logic        c_sus;

  ccdr_pix_class #(
    .PW (`CCDR_PCNT_W),
    .LW (`CCDR_LCNT_W)
  ) u_class (
    .i_pix        (s_q.pix),
    .i_line       (s_q.line),
    .o_kind       (c_kind),
    .o_dark_clean (c_clean),
    .o_buffer     (c_buf),
    .o_suspect    (c_sus)
  );

  // ***************
  // Next state
  // ***************
  always_comb begin
    s_d = s_q;
    s_d.smp = 1'b0;
    s_d.done = 1'b0;
    s_d.rg = 1'b0;
    unique case (s_q.st)
      ST_IDLE: begin
        s_d.va = 1'b0;
        s_d.vb = 1'b0;
        s_d.ha = 1'b0;
        s_d.hb = 1'b1;
        if (I_START) begin
          s_d.st = ST_INTEG;
          s_d.cnt = (I_INTEG_LEN != '0) ? I_INTEG_LEN : `CCDR_VCNT_W'(INTEG_CYC);
          s_d.line = '0;
        end
      end
      ST_INTEG: begin
        s_d.va = 1'b0;
        s_d.vb = 1'b0;
        if (s_q.cnt <= `CCDR_VCNT_W'(1)) begin
          s_d.st = ST_V1;
          s_d.cnt = `CCDR_VCNT_W'(VPH_CYC);
          s_d.va = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - `CCDR_VCNT_W'(1);
        end
      end
      ST_V1: begin
        s_d.hb = 1'b1;
        s_d.ha = 1'b0;
        if (s_q.cnt <= `CCDR_VCNT_W'(1)) begin
          s_d.st = ST_V2;
          s_d.vb = 1'b1;
          s_d.cnt = `CCDR_VCNT_W'(VPH_CYC);
        end else begin
          s_d.cnt = s_q.cnt - `CCDR_VCNT_W'(1);
        end
      end
      ST_V2: begin
        if (s_q.cnt <= `CCDR_VCNT_W'(1)) begin
          s_d.st = ST_HOLD;
          s_d.va = 1'b0;
          s_d.cnt = `CCDR_VCNT_W'(VPH_CYC);
        end else begin
          s_d.cnt = s_q.cnt - `CCDR_VCNT_W'(1);
        end
      end
      ST_HOLD: begin
        if (s_q.cnt == `CCDR_VCNT_W'(VPH_CYC / 2)) begin
          s_d.vb = 1'b0;
        end
        // Setup before horizontal clocking starts
        if (s_q.cnt <= `CCDR_VCNT_W'(1)) begin
          s_d.st = ST_HSHIFT;
          s_d.pix = '0;
          s_d.ph = '0;
          s_d.ha = 1'b1;
          s_d.hb = 1'b0;
        end else begin
          s_d.cnt = s_q.cnt - `CCDR_VCNT_W'(1);
        end
      end
      ST_HSHIFT: begin
        s_d.ph = s_q.ph + 3'd1;
        if (s_q.ph == 3'(PIX_CYC / 2)) begin
          s_d.ha = 1'b0;
          s_d.hb = 1'b1;
        end
        if (s_q.ph == 3'(PIX_CYC / 2 + 1)) begin
          // Packet settles after ha fall; sample it, then reset
          s_d.smp = 1'b1;
          s_d.kind = c_kind;
          s_d.clean = c_clean;
          s_d.buf_f = c_buf;
          s_d.sus = c_sus;
        end
        if (s_q.ph == 3'(PIX_CYC / 2 + 2)) begin
          s_d.rg = 1'b1;
        end
        if (s_q.ph == 3'(PIX_CYC - 1)) begin
          s_d.ph = '0;
          if (s_q.pix == LINE_PIX - `CCDR_PCNT_W'(1)) begin
            s_d.hb = 1'b1;
            s_d.pix = '0;
            if (s_q.line == FRAME_LINES - `CCDR_LCNT_W'(1)) begin
              s_d.st = ST_IDLE;
              s_d.done = 1'b1;
            end else begin
              s_d.line = s_q.line + `CCDR_LCNT_W'(1);
              s_d.st = ST_V1;
              s_d.va = 1'b1;
              s_d.cnt = `CCDR_VCNT_W'(VPH_CYC);
            end
          end else begin
            s_d.pix = s_q.pix + `CCDR_PCNT_W'(1);
            s_d.ha = 1'b1;
            s_d.hb = 1'b0;
          end
        end
      end
    endcase
    // Registered so the busy pin comes straight from a flop
    s_d.busy = (s_d.st != ST_IDLE);
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      s_q <= '{st: ST_IDLE, kind: PX_DUMMY_LEAD, hb: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign O_VERT_CLK_A    = s_q.va;
  assign O_VERT_CLK_B    = s_q.vb;
  assign O_HORIZ_CLK_A   = s_q.ha;
  assign O_HORIZ_CLK_B   = s_q.hb;
  assign O_FD_RESET_GATE = s_q.rg;
  assign O_SAMPLE        = s_q.smp;
  assign O_PIX_KIND      = s_q.kind;
  assign O_DARK_CLEAN    = s_q.clean;
  assign O_BUFFER        = s_q.buf_f;
  assign O_SUSPECT       = s_q.sus;
  assign O_PIX           = s_q.pix;
  assign O_LINE          = s_q.line;
  assign O_BUSY          = s_q.busy;
  assign O_FRAME_DONE    = s_q.done;

  // ***************
  // Checks
  // ***************
  a_integ_vlow: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    s_q.st == ST_INTEG |-> !s_q.va && !s_q.vb) else $error("vertical clock moved in exposure");
  a_row_xfer_hb: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    $fell(s_q.va) |-> s_q.hb) else $error("row transfer without horiz_clk_b high");
  a_h_compl: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    s_q.st == ST_HSHIFT |-> s_q.ha != s_q.hb) else $error("horizontal clocks not complementary");
  a_sample_after: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    $fell(s_q.ha) && s_q.st == ST_HSHIFT |=> s_q.smp) else $error("no sample after ha fall");
  a_reset_after: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    s_q.smp |=> s_q.rg) else $error("reset gate not after sample");
  a_rg_each_pix: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    s_q.rg && s_q.st == ST_HSHIFT |-> ##5 s_q.rg) else $error("reset gate missed a pixel");
  a_rg_period: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    s_q.rg |=> !s_q.rg [*4]) else $error("pixel period wrong");
  a_no_v_midline: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    s_q.st == ST_HSHIFT && s_q.pix != LINE_PIX - `CCDR_PCNT_W'(1) |-> !s_q.va)
    else $error("vertical transfer before line end");
endmodule : ccdr_seq

// File: ccdr_dev_model.sv
// Behavioural full-frame CCD that answers and polices the sequencer clocks
module ccdr_dev_model (
  // Clocks from the sequencer
  input  wire logic i_reset_n,
  input  wire logic i_vert_clk_a,
  input  wire logic i_horiz_clk_a,
  input  wire logic i_horiz_clk_b,
  input  wire logic i_fd_reset_gate,
  input  wire logic i_sample,
  // Video and bookkeeping
  output logic [7:0] o_video,
  output int         o_rows,
  output int         o_errs
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Geometry
  // ****************************************
  localparam int DUM_LEAD = 12;
  localparam int DUM_TAIL = 2;
  localparam int DARK_COL = 34;
  localparam int ACT_COL  = 2614;
  localparam int BUF_PIX  = 20;
  localparam int LEAD_ROW = 34;
  localparam int TAIL_ROW = 4;
  localparam int ACT_ROW  = 1966;
  localparam int STAGES   = DUM_LEAD + 2 * DARK_COL + ACT_COL + DUM_TAIL;
  localparam int ROWS     = LEAD_ROW + ACT_ROW + TAIL_ROW;
  int      n_ha, n_rg, n_smp;
  logic    packet, sampled;
  realtime t_fall;
  // Signal level per stage; marked levels stand for unreliable references
  function automatic logic [7:0] level(int s, int r);
    int a;
    a = s - DUM_LEAD - DARK_COL;
    if (s < DUM_LEAD) return (s < 2) ? 8'h30 : 8'h08;
    if (s >= STAGES - DUM_TAIL) return 8'h08;
    if (r < LEAD_ROW || r >= LEAD_ROW + ACT_ROW) return (r < 2) ? 8'h20 : 8'h10;
    if (a < 0 || a >= ACT_COL) return 8'h10;
    if (a < BUF_PIX || a >= ACT_COL - BUF_PIX) return 8'h60;
    return 8'h80;
  endfunction
  task automatic clear;
    o_rows  = 0;
    o_errs  = 0;
    n_ha    = 0;
    n_rg    = 0;
    n_smp   = 0;
    packet  = 0;
    sampled = 0;
    t_fall  = 0;
    o_video = 8'h00;
  endtask
  initial clear();
  always @(negedge i_reset_n) clear();
  // ****************************************
  // Transport and output stage
  // ****************************************
  always @(negedge i_vert_clk_a) if (i_reset_n) begin
    if (i_horiz_clk_b !== 1'b1) o_errs++;
    if (o_rows > 0 && (n_ha != STAGES || n_rg != STAGES || n_smp != STAGES)) o_errs++;
    if (o_rows == 0 && n_ha != 0) o_errs++;
    if (o_rows >= ROWS) o_errs++;
    o_rows++;
    n_ha   = 0;
    n_rg   = 0;
    n_smp  = 0;
    t_fall = 0;
  end
  always @(negedge i_horiz_clk_a) if (i_reset_n) begin
    if (t_fall > 0 && $realtime - t_fall != 250.0) o_errs++;
    if (n_ha >= STAGES || packet) o_errs++;
    t_fall  = $realtime;
    o_video = level(n_ha, o_rows - 1);
    n_ha++;
    packet  = 1;
    sampled = 0;
  end
  always @(posedge i_sample) if (i_reset_n) begin
    n_smp++;
    sampled = packet;
  end
  // Clearing an unsampled packet would lose the pixel
  always @(posedge i_fd_reset_gate) if (i_reset_n) begin
    if (packet && !sampled) o_errs++;
    n_rg++;
    packet  = 0;
    o_video = 8'h00;
  end
  always @(i_horiz_clk_a or i_horiz_clk_b) #1 if (i_reset_n && i_horiz_clk_a === i_horiz_clk_b)
    o_errs++;
endmodule // ccdr_dev_model

// File: tb_top.sv
// Testbench driving the readout sequencer into the behavioural CCD
module tb_top import ccdr_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic        I_CLK = 0, I_RESET_N = 0, I_START = 0;
  logic [15:0] I_INTEG_LEN = 16'h0014;
  logic        va, vb, ha, hb, rg, smp, dclean, buf_f, susp, busy, fdone;
  ccdr_pix_e   kind;
  logic [7:0]  video;
  logic [11:0] pix, line;
  int          rows, dev_errs, failures = 0, n_checks = 0;
  always #25 I_CLK = ~I_CLK;
  ccdr_seq #(.INTEG_CYC(64), .VPH_CYC(4), .HS_CYC(4)) uut (
    .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_START(I_START), .I_INTEG_LEN(I_INTEG_LEN),
    .O_VERT_CLK_A(va), .O_VERT_CLK_B(vb), .O_HORIZ_CLK_A(ha), .O_HORIZ_CLK_B(hb),
    .O_FD_RESET_GATE(rg), .O_SAMPLE(smp), .O_PIX_KIND(kind), .O_DARK_CLEAN(dclean),
    .O_BUFFER(buf_f), .O_SUSPECT(susp), .O_PIX(pix), .O_LINE(line), .O_BUSY(busy),
    .O_FRAME_DONE(fdone));
  ccdr_dev_model dev (
    .i_reset_n(I_RESET_N), .i_vert_clk_a(va), .i_horiz_clk_a(ha), .i_horiz_clk_b(hb),
    .i_fd_reset_gate(rg), .i_sample(smp), .o_video(video), .o_rows(rows), .o_errs(dev_errs));
  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done;
    if (failures == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check_idle;
    check("idle_pins", {va, vb, ha, hb, rg, smp, busy, fdone}, 8'h10);
  endtask
  function automatic ccdr_pix_e dark_kind(int p);
    if (p < 12) return PX_DUMMY_LEAD;
    if (p >= 2694) return PX_DUMMY_TAIL;
    return PX_DARK;
  endfunction
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    repeat (5) @(negedge I_CLK);
    check_idle();
    @(negedge I_CLK);
    I_RESET_N = 1;
  endtask
  // Vertical clocks must idle low for the whole exposure
  task automatic t_expose;
    int cnt;
    int bad;
    cnt = 0;
    bad = 0;
    I_START = 1;
    @(negedge I_CLK);
    I_START = 0;
    while (va !== 1'b1) begin
      if (vb !== 1'b0 || busy !== 1'b1) bad++;
      cnt++;
      if (cnt > 300) begin
        failures++;
        test_done();
      end
      @(negedge I_CLK);
    end
    check("expose_steady", bad, 0);
    check("expose_len", cnt, 20);
  endtask
  // Three dark lines; a start request mid-readout must be ignored
  task automatic t_lines;
    int p;
    int n;
    int last;
    p = 0;
    n = 0;
    last = rows;
    while (rows < 4) begin
      if (rows != last) p = 0;
      last = rows;
      I_START = (rows == 2 && p == 5);
      if (smp === 1'b1) begin
        check("kind", kind, dark_kind(p));
        check("buffer", buf_f, 0);
        if (rows < 3) check("suspect_edge", susp, p < 2694);
        if (rows == 3 && p < 12) check("suspect_lead", susp, 1);
        if (rows == 3 && p == 1000) check("dark_clean", {dclean, susp}, 2'b10);
        check("pix", pix, p);
        check("line", line, rows - 1);
        check("video_present", video != 8'h00, 1);
        p++;
      end
      n++;
      if (n > 60000) begin
        failures++;
        test_done();
      end
      @(negedge I_CLK);
    end
    check("device_errs", dev_errs, 0);
    check("busy_readout", busy, 1);
  endtask
  task automatic t_midreset;
    I_RESET_N = 0;
    @(negedge I_CLK);
    check_idle();
    check("dev_rows", rows, 0);
    I_RESET_N = 1;
    repeat (3) @(negedge I_CLK);
    check("busy_after", busy, 0);
  endtask
  initial begin
    t_reset();
    t_expose();
    t_lines();
    t_midreset();
    test_done();
  end
endmodule // tb_top
